// >>> logic/timer_channel.v
// One channel of a 16-bit reload timer: timer and event counter modes, APB registers.
// Assumes clk is the system clock; oscillator and subclock ticks and neighbour events
// arrive as one-cycle pulses synchronous to clk.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "timer_chan_regs.vh"

module timer_channel #(
    parameter WIDTH = 16
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        fast_osc_tick,
    input  wire        slow_osc_tick,
    input  wire        subclock_tick,
    input  wire        timer_b2_event,
    input  wire        lower_event,
    input  wire        upper_event,
    input  wire        timer_input_pin,
    output reg         timer_output_pin,
    output reg         irq_request
);

    reg  [7:0]       mode_reg;
    reg  [7:0]       ctrl_reg;
    reg  [7:0]       src_reg;
    reg  [WIDTH-1:0] count_reg;
    reg  [WIDTH-1:0] reload_reg;
    reg              started_reg;
    reg  [5:0]       div_reg;
    reg              pin_q_reg;
    reg              pulse_reg;
    reg              wrap_seen_reg;

    wire [1:0] op_mode   = mode_reg[`MODE_OP_HI:`MODE_OP_LO];
    wire       run       = ctrl_reg[`CTRL_RUN];
    wire       up_dir    = ctrl_reg[`CTRL_DIR];
    wire       free_run  = ctrl_reg[`CTRL_FREE];
    wire       invert    = ctrl_reg[`CTRL_INV];
    wire [1:0] ev_sel    = ctrl_reg[`CTRL_EVSEL_HI:`CTRL_EVSEL_LO];
    wire       is_timer  = (op_mode == `OP_TIMER);
    wire       is_event  = (op_mode == `OP_EVENT);

    wire apb_access = psel & penable;
    wire apb_wr     = apb_access & pwrite;

    // Shared divider; input is system clock or fast oscillator
    wire div_in = src_reg[`SRC_PREDIV] ? fast_osc_tick : 1'b1;
    wire [5:0] div_inc = div_reg + 6'h01;
    wire tick_f1  = div_in;
    wire tick_f2  = div_in & (div_reg[0] == 1'b1);
    wire tick_f8  = div_in & (div_reg[2:0] == 3'h7);
    wire tick_f32 = div_in & (div_reg[4:0] == 5'h1f);
    wire tick_f64 = div_in & (div_reg == 6'h3f);
    wire tick_low = src_reg[`SRC_DIV1] ? tick_f1 : tick_f2;

    reg internal_tick;
    always @* begin
        internal_tick = 1'b0;
        if (src_reg[`SRC_EXTEND]) begin
            case (src_reg[`SRC_CODE_HI:`SRC_CODE_LO])
                3'h0:    internal_tick = tick_low;
                3'h1:    internal_tick = tick_f8;
                3'h2:    internal_tick = tick_f32;
                3'h3:    internal_tick = tick_f64;
                3'h4:    internal_tick = fast_osc_tick;
                3'h5:    internal_tick = slow_osc_tick;
                3'h6:    internal_tick = subclock_tick;
                default: internal_tick = 1'b0;
            endcase
        end else begin
            case (mode_reg[`MODE_LEG_HI:`MODE_LEG_LO])
                2'h0:    internal_tick = tick_low;
                2'h1:    internal_tick = tick_f8;
                2'h2:    internal_tick = tick_f32;
                default: internal_tick = subclock_tick;
            endcase
        end
    end

    // Event selection; pin edge polarity matters only for the pin source
    wire pin_rise = timer_input_pin & ~pin_q_reg;
    wire pin_fall = ~timer_input_pin & pin_q_reg;
    wire pin_edge = mode_reg[`MODE_EDGE_POL] ? pin_rise : pin_fall;
    reg  event_tick;
    always @* begin
        case (ev_sel)
            `EV_PIN:   event_tick = pin_edge;
            `EV_B2:    event_tick = timer_b2_event;
            `EV_LOWER: event_tick = lower_event;
            `EV_UPPER: event_tick = upper_event;
            default:   event_tick = 1'b0;
        endcase
    end

    // Gate level on the input pin enables counting in timer mode
    wire gate_ok = ~mode_reg[`MODE_GATE_EN] |
                   (timer_input_pin == mode_reg[`MODE_GATE_LVL]);
    wire active  = run & (is_timer ? gate_ok : is_event);
    wire tick    = active & (is_timer ? internal_tick : event_tick);
    wire count_up = is_event & up_dir;
    wire at_end   = count_up ? (count_reg == `COUNT_MAX) : (count_reg == `COUNT_ZERO);
    wire wrap     = tick & started_reg & at_end;
    wire cnt_wr   = apb_wr & (paddr == `ADDR_COUNT);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_reg   <= 6'h00;
            pin_q_reg <= 1'b0;
        end else begin
            if (div_in) begin
                div_reg <= div_inc;
            end
            pin_q_reg <= timer_input_pin;
        end
    end

    // Registers and counter
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg    <= `MODE_RESET;
            ctrl_reg    <= `CTRL_RESET;
            src_reg     <= `SRC_RESET;
            count_reg   <= `COUNT_ZERO;
            reload_reg  <= `COUNT_ZERO;
            started_reg <= 1'b0;
        end else begin
            if (apb_wr && paddr == `ADDR_MODE) begin
                mode_reg <= pwdata[7:0];
            end
            if (apb_wr && paddr == `ADDR_CTRL) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (apb_wr && paddr == `ADDR_SRC) begin
                src_reg <= pwdata[7:0];
            end
            if (!run) begin
                started_reg <= 1'b0;
            end else if (tick) begin
                started_reg <= 1'b1;
            end
            if (cnt_wr) begin
                reload_reg <= pwdata[WIDTH-1:0];
            end
            if (cnt_wr && (!run || !started_reg)) begin
                count_reg <= pwdata[WIDTH-1:0];
            end else if (tick && started_reg) begin
                if (wrap && !(is_event && free_run)) begin
                    count_reg <= reload_reg;
                end else if (count_up) begin
                    count_reg <= count_reg + 16'h0001;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end

    // Output pin, interrupt request and sticky wrap status
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_reg        <= 1'b0;
            timer_output_pin <= 1'b0;
            irq_request      <= 1'b0;
            wrap_seen_reg    <= 1'b0;
        end else begin
            if (!run) begin
                pulse_reg <= 1'b0;
            end else if (wrap && mode_reg[`MODE_PULSE_EN]) begin
                pulse_reg <= ~pulse_reg;
            end
            timer_output_pin <= (mode_reg[`MODE_PULSE_EN] & (run ? pulse_reg : 1'b0)) ^
                                (mode_reg[`MODE_PULSE_EN] & invert);
            irq_request <= wrap;
            if (wrap) begin
                wrap_seen_reg <= 1'b1;
            end else if (apb_wr && paddr == `ADDR_STATUS && pwdata[0]) begin
                wrap_seen_reg <= 1'b0;
            end
        end
    end

    // APB slave: zero wait states, error on unmapped address
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    `ADDR_MODE:   prdata <= {24'h000000, mode_reg};
                    `ADDR_COUNT:  prdata <= {16'h0000, count_reg};
                    `ADDR_CTRL:   prdata <= {24'h000000, ctrl_reg};
                    `ADDR_SRC:    prdata <= {24'h000000, src_reg};
                    `ADDR_STATUS: prdata <= {30'h00000000, started_reg, wrap_seen_reg};
                    default:      pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// >>> shared/timer_chan_regs.vh
// Register offsets, field positions and reset values of one reload timer channel.
// Included by the channel logic; APB byte addresses, one 32-bit word per register.
`ifndef TIMER_CHAN_REGS_VH
`define TIMER_CHAN_REGS_VH

`define ADDR_MODE          8'h00
`define ADDR_COUNT         8'h04
`define ADDR_CTRL          8'h08
`define ADDR_SRC           8'h0c
`define ADDR_STATUS        8'h10

`define MODE_RESET         8'h00
`define CTRL_RESET         8'h00
`define SRC_RESET          8'h00

// Mode register fields
`define MODE_OP_LO         0
`define MODE_OP_HI         1
`define MODE_PULSE_EN      2
`define MODE_EDGE_POL      3
`define MODE_GATE_EN       4
`define MODE_GATE_LVL      5
`define MODE_LEG_LO        6
`define MODE_LEG_HI        7

`define OP_TIMER           2'b00
`define OP_EVENT           2'b01

// Control register fields
`define CTRL_RUN           0
`define CTRL_DIR           1
`define CTRL_FREE          2
`define CTRL_INV           3
`define CTRL_EVSEL_LO      4
`define CTRL_EVSEL_HI      5

// Source select register fields
`define SRC_CODE_LO        0
`define SRC_CODE_HI        2
`define SRC_EXTEND         3
`define SRC_DIV1           4
`define SRC_PREDIV         5

`define EV_PIN             2'b00
`define EV_B2              2'b01
`define EV_LOWER           2'b10
`define EV_UPPER           2'b11

`define COUNT_MAX          16'hffff
`define COUNT_ZERO         16'h0000

`endif

// >>> verif/timer_channel_chk.sv
// Port-level checks for one reload timer channel.
// Bound to timer_channel; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_output_pin,
    input wire logic        irq_request
);
    wire logic wr_done = psel && penable && pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access answered");
    AST_COUNT_WIDTH: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[31:16] == 16'h0)
        else $error("count read too wide");
    AST_MODE_WIDTH: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:8] == 24'h0)
        else $error("mode read too wide");
    AST_OUT_CAUSE: assert property ($changed(timer_output_pin) |-> irq_request || $past(irq_request) || $past(wr_done) || $past(wr_done, 2))
        else $error("output moved without wrap or write");
endmodule
bind timer_channel timer_channel_chk chk_i (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(timer_output_pin), .irq_request(irq_request));
`default_nettype wire

// >>> verif/ext_pulses.sv
// Far side of the channel: source ticks, neighbour events and the input pin.
// Periodic ticks of 5, 7 and 11 cycles; events fire one cycle after req.
`timescale 1ns/1ps
`default_nettype none
module ext_pulses (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       req,
    input  wire logic [1:0] sel,
    output var  logic [6:0] ev
);
    logic [8:0] c;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c  <= 9'h0;
            ev <= 7'h0;
        end else begin
            c     <= (c == 9'd384) ? 9'h0 : c + 9'h1;
            ev[0] <= (c % 5) == 0;
            ev[1] <= (c % 7) == 0;
            ev[2] <= (c % 11) == 0;
            ev[3] <= req && sel == 2'b01;
            ev[4] <= req && sel == 2'b10;
            ev[5] <= req && sel == 2'b11;
            ev[6] <= req && sel == 2'b00;
        end
    end
endmodule
`default_nettype wire

// >>> verif/timer_channel_bench.sv
// Self-checking bench for the timer channel over APB.
// Far side is ext_pulses; checker attaches by bind.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_bench;
    logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0]  sel = 2'b00;
    logic [6:0]  ev;
    logic        pready, pslverr, out, irq, e;
    int          err_count = 0, tests_run = 0, cyc = 0, irq_cnt = 0, t_prev = 0, t_last = 0;
    // Source register, mode register, tick period of the source
    localparam logic [23:0] TBL [7] = '{24'h0c0405, 24'h0d0407, 24'h0e040b, 24'h00c40b,
                                        24'h100401, 24'h090408, 24'h290428};
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1) begin
            irq_cnt++;
            t_prev = t_last;
            t_last = cyc;
        end
    end
    timer_channel dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_osc_tick(ev[0]), .slow_osc_tick(ev[1]),
        .subclock_tick(ev[2]), .timer_b2_event(ev[3]), .lower_event(ev[4]),
        .upper_event(ev[5]), .timer_input_pin(ev[6]), .timer_output_pin(out),
        .irq_request(irq));
    ext_pulses src (.clk(clk), .resetn(resetn), .req(req), .sel(sel), .ev(ev));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin err_count++; print_verdict; end
        q = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic fire(input int k);
        repeat (k) begin @(posedge clk); req <= 1'b1; @(posedge clk); req <= 1'b0; end
    endtask
    task automatic wait2;
        int s, i;
        s = irq_cnt; i = 0;
        while (irq_cnt < s + 2 && i < 1000) begin @(posedge clk); i++; end
        if (irq_cnt < s + 2) begin err_count++; print_verdict; end
    endtask
    initial begin
        int n, m, up;
        void'($urandom(32'h79a01f75));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        apb(0, 8'h00, 0); chk("mode reset", 0, q);
        apb(0, 8'h08, 0); chk("ctrl reset", 0, q);
        apb(0, 8'h0c, 0); chk("src reset", 0, q);
        apb(0, 8'h40, 0); chk("unmapped err", 1, e); chk("unmapped data", 0, q);
        apb(1, 8'h04, 32'h1234); apb(0, 8'h04, 0); chk("count", 32'h1234, q);
        apb(1, 8'h00, 32'h04); repeat (2) @(posedge clk); chk("out idle", 0, out);
        apb(1, 8'h08, 32'h08); repeat (2) @(posedge clk); chk("out inv", 1, out);
        foreach (TBL[k]) begin
            n = $urandom_range(4, 1);
            apb(1, 8'h08, 0); apb(1, 8'h0c, TBL[k][23:16]); apb(1, 8'h00, TBL[k][15:8]);
            apb(1, 8'h04, n); apb(1, 8'h08, 1);
            wait2;
            chk("period", (n + 1) * TBL[k][7:0], t_last - t_prev);
        end
        for (int s = 0; s < 4; s++) begin
            n = $urandom_range(4, 1);
            up = $urandom_range(1, 0);
            apb(1, 8'h08, 0); apb(1, 8'h00, 8'h09); apb(1, 8'h04, up ? 32'hffff - n : n);
            sel <= s[1:0];
            apb(1, 8'h08, 1 + up * 2 + s * 16);
            m = irq_cnt;
            fire(n + 1); repeat (4) @(posedge clk);
            chk("early wrap", m, irq_cnt);
            fire(1); repeat (4) @(posedge clk);
            chk("event wrap", m + 1, irq_cnt);
        end
        apb(1, 8'h08, 0); apb(1, 8'h04, 32'hfffe); sel <= 2'b10; apb(1, 8'h08, 32'h27);
        fire(4); apb(0, 8'h04, 0); chk("free run", 1, q);
        apb(1, 8'h04, 32'h0100); apb(0, 8'h04, 0); chk("running write", 1, q);
        apb(0, 8'h10, 0); chk("status", 3, q);
        apb(1, 8'h10, 1); apb(0, 8'h10, 0); chk("status clear", 2, q);
        apb(1, 8'h08, 0); apb(1, 8'h0c, 8'h10); apb(1, 8'h00, 8'h34);
        apb(1, 8'h04, 2); apb(1, 8'h08, 1);
        repeat (20) @(posedge clk);
        apb(0, 8'h04, 0); chk("gate hold", 2, q);
        apb(1, 8'h00, 8'h14);
        wait2;
        chk("gate open", 3, t_last - t_prev);
        print_verdict;
    end
endmodule
`default_nettype wire
